// [pkg/fst_params.svh]
// Constants of the flash strobe mode timer: offsets, fields, resets, times.
// Assumes a 100 MHz clock; included by the design.
`ifndef FST_PARAMS_SVH
`define FST_PARAMS_SVH
////////////////////////////////////////////////////////////////////////////////
`define FST_ADDR_MODE 4'h0
`define FST_ADDR_CFG 4'h4
`define FST_ADDR_LEVEL 4'h8
`define FST_ADDR_STATUS 4'hc
`define FST_MODE_LSB 0
`define FST_SW_BIT 2
`define FST_TTYPE_BIT 3
`define FST_DUR_LSB 0
`define FST_SINK_LSB 4
`define FST_RES_BIT 8
`define FST_PSM_BIT 9
`define FST_TORCH_LSB 0
`define FST_FLASH_LSB 8
`define FST_VOUT_LSB 16
`define FST_ST_FLASH_BIT 0
`define FST_ST_RUN_BIT 1
`define FST_ST_DOWN_BIT 2
`define FST_ST_PSM_BIT 3
`define FST_ST_WD_BIT 4
`define FST_ST_STEP_LSB 8
`define FST_ST_STATE_LSB 16
`define FST_CFG_MASK 32'h0000_0377
`define FST_LEVEL_MASK 32'h000f_0f0f
`define FST_CFG_RST 32'h0000_0277
`define FST_LEVEL_RST 32'h0000_0000
`define FST_RESP_OKAY 2'h0
`define FST_RESP_SLVERR 2'h2
////////////////////////////////////////////////////////////////////////////////
`define FST_CLK_NS 10
`define FST_RISE_NS 12000
`define FST_FALL_NS 500
`define FST_HC_STEP_NS 500
`define FST_RISE_CYC ((`FST_RISE_NS + `FST_CLK_NS - 1) / `FST_CLK_NS)
`define FST_FALL_CYC ((`FST_FALL_NS + `FST_CLK_NS - 1) / `FST_CLK_NS)
`define FST_HC_CYC ((`FST_HC_STEP_NS + `FST_CLK_NS - 1) / `FST_CLK_NS)
`define FST_WD_MS 11200
`define FST_WD_CYC (`FST_WD_MS * (1000000 / `FST_CLK_NS))
`define FST_FLASH_DURATION_SELECT_UNIT_US 100
`define FST_FLASH_DURATION_SELECT_UNIT_CYC (`FST_FLASH_DURATION_SELECT_UNIT_US * (1000 / `FST_CLK_NS))
`define FST_VOUT_FORCE 4'h9
`define FST_QMA_DD 8'h64
`define FST_QMA_HC 8'he1
`endif

// [pkg/fst_pkg.sv]
// Types shared by the flash strobe mode timer.
// Assumes nothing beyond a SystemVerilog compiler.
package fst_pkg;
  typedef enum logic [1:0] {
    MD_OFF = 2'h0,
    MD_TORCH = 2'h1,
    MD_FLASH = 2'h2,
    MD_VOLT = 2'h3
  } fst_mode_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LEVEL = 4'h2,
    ST_SHOT = 4'h4,
    ST_HOLD = 4'h8
  } fst_state_e;
  typedef struct packed {
    logic psm;
    logic res;
    logic [2:0] sink;
    logic [2:0] dur;
  } fst_cfg_s;
  typedef struct packed {
    logic [2:0] sink_en;
    logic [3:0] step;
    logic [11:0] current_qma;
  } fst_led_s;
endpackage

// [hdl/fst_timer.sv]
// Mode, strobe timer, torch watchdog and LED current ramp of a flash driver.
// Assumes an AXI4-Lite master on aclk and asynchronous pins from outside.
//
// Contract
// - In voltage mode enter down mode at vin>=vout, leave 200mV below.
// - Reverse energy transfer only while output stays above input.
// - Direct drive ramps 25mA steps: 12us per rise, 0.5us per fall.
// - Reservoir mode ramps 56.25mA steps of 0.5us both directions.
// - Reservoir mode scales every current setting by 2.25.
// - Light-load save follows its enable, forced on in down mode.
// - With force low, mode 00 is shutdown.
// - Mode 01 drives torch current, ignoring strobe pin and bit.
// - Torch needs a mode rewrite within 11.2s or device shuts down.
// - Mode 11 regulates voltage, sinks and safety timer disabled.
// - Mode 10 accepts strobe from pin or software bit.
// - Level type: flash while trigger high, else torch, duration-limited.
// - Level type: safety timer starts on a trigger rising edge.
// - Level type: timer stops on trigger low or on timeout.
// - Timeout clears the software strobe bit in both types.
// - Edge type: rising edge starts a one-shot pulse of set duration.
// - Edge type: while running ignore all triggers, end on timeout.
// - Edge type: torch current while both triggers are low.
// - Safety timer is clocked by the internal oscillator.
// - Force pin high gives voltage mode with fixed 4.95V output.
`include "fst_params.svh"
module fst_timer #(
  parameter int unsigned WD_CYC = `FST_WD_CYC,
  parameter int unsigned FLASH_DURATION_SELECT_UNIT_CYC = `FST_FLASH_DURATION_SELECT_UNIT_CYC,
  parameter int unsigned RISE_CYC = `FST_RISE_CYC,
  parameter int unsigned FALL_CYC = `FST_FALL_CYC,
  parameter int unsigned HC_CYC = `FST_HC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic strobe_pin,
  input wire logic voltage_mode_force,
  input wire logic vin_ge_vout,
  input wire logic vin_below_vout_200mv,
  input wire logic vout_above_vin,
  input wire logic vout_above_target,
  output fst_pkg::fst_led_s led,
  output logic shutdown,
  output logic vm_active,
  output logic [3:0] output_voltage_select,
  output logic down_mode,
  output logic psm_active,
  output logic reverse_en,
  output logic flash_active,
  output logic timer_timeout_event
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] o);
    addr_hit = ({a[3:2], 2'h0} == o);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb,
                                        input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~m) | (data & m);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  logic [4:0] pin_raw;
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  assign pin_raw = {vout_above_target, vout_above_vin, vin_below_vout_200mv,
                    vin_ge_vout, strobe_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate
  logic force_meta;
  logic force_s;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_meta <= 1'b0;
      force_s <= 1'b0;
    end else begin
      force_meta <= voltage_mode_force;
      force_s <= force_meta;
    end
  end
  logic strobe_s;
  logic strobe_d;
  assign strobe_s = pin_sync[0];
  ////////////////////////////////////////////////////////////////////////////
  logic wr_go;
  logic mode_wr;
  logic [1:0] wr_resp;
  fst_pkg::fst_mode_e mode;
  logic sw_bit;
  logic sw_d;
  logic ttype;
  logic [31:0] cfg_q;
  logic [31:0] lvl_q;
  fst_pkg::fst_cfg_s cfg;
  fst_pkg::fst_state_e state;
  logic [31:0] tmr_cnt;
  logic [31:0] wd_cnt;
  logic wd_expire;
  logic wd_fired;
  logic [3:0] step;
  logic [3:0] target;
  logic [15:0] ramp_cnt;
  logic [15:0] period;
  logic sinks_on;
  logic torch_on;
  logic trig_level;
  logic trig_rise;
  logic timer_run;
  assign cfg = fst_pkg::fst_cfg_s'({cfg_q[`FST_PSM_BIT], cfg_q[`FST_RES_BIT],
                                    cfg_q[`FST_SINK_LSB +: 3],
                                    cfg_q[`FST_DUR_LSB +: 3]});
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign mode_wr = wr_go && addr_hit(s_axi_awaddr, `FST_ADDR_MODE)
                   && s_axi_wstrb[0];
  assign wr_resp = (addr_hit(s_axi_awaddr, `FST_ADDR_MODE) ||
                    addr_hit(s_axi_awaddr, `FST_ADDR_CFG) ||
                    addr_hit(s_axi_awaddr, `FST_ADDR_LEVEL) ||
                    addr_hit(s_axi_awaddr, `FST_ADDR_STATUS)) ?
                   `FST_RESP_OKAY : `FST_RESP_SLVERR;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FST_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_resp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  // A mode rewrite wins over a watchdog expiry in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= fst_pkg::MD_OFF;
      ttype <= 1'b0;
    end else if (mode_wr) begin
      mode <= fst_pkg::fst_mode_e'(s_axi_wdata[`FST_MODE_LSB +: 2]);
      ttype <= s_axi_wdata[`FST_TTYPE_BIT];
    end else if (wd_expire) begin
      mode <= fst_pkg::MD_OFF;
    end
  end
  // A software write of the strobe bit wins over the clearing timeout.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_bit <= 1'b0;
    end else if (mode_wr) begin
      sw_bit <= s_axi_wdata[`FST_SW_BIT];
    end else if (timer_timeout_event || shutdown) begin
      sw_bit <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= `FST_CFG_RST;
      lvl_q <= `FST_LEVEL_RST;
    end else if (wr_go) begin
      if (addr_hit(s_axi_awaddr, `FST_ADDR_CFG)) begin
        cfg_q <= merge(cfg_q, s_axi_wdata, s_axi_wstrb, `FST_CFG_MASK);
      end
      if (addr_hit(s_axi_awaddr, `FST_ADDR_LEVEL)) begin
        lvl_q <= merge(lvl_q, s_axi_wdata, s_axi_wstrb, `FST_LEVEL_MASK);
      end
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `FST_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FST_RESP_OKAY;
      s_axi_rdata <= 32'h0;
      if (addr_hit(s_axi_araddr, `FST_ADDR_MODE)) begin
        s_axi_rdata <= {28'h0, ttype, sw_bit, mode};
      end else if (addr_hit(s_axi_araddr, `FST_ADDR_CFG)) begin
        s_axi_rdata <= cfg_q;
      end else if (addr_hit(s_axi_araddr, `FST_ADDR_LEVEL)) begin
        s_axi_rdata <= lvl_q;
      end else if (addr_hit(s_axi_araddr, `FST_ADDR_STATUS)) begin
        s_axi_rdata[`FST_ST_FLASH_BIT] <= flash_active;
        s_axi_rdata[`FST_ST_RUN_BIT] <= timer_run;
        s_axi_rdata[`FST_ST_DOWN_BIT] <= down_mode;
        s_axi_rdata[`FST_ST_PSM_BIT] <= psm_active;
        s_axi_rdata[`FST_ST_WD_BIT] <= wd_fired;
        s_axi_rdata[`FST_ST_STEP_LSB +: 4] <= step;
        s_axi_rdata[`FST_ST_STATE_LSB +: 4] <= state;
      end else begin
        s_axi_rresp <= `FST_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign shutdown = (mode == fst_pkg::MD_OFF) && !force_s;
  assign vm_active = force_s || (mode == fst_pkg::MD_VOLT);
  assign output_voltage_select = force_s ? `FST_VOUT_FORCE :
                                 lvl_q[`FST_VOUT_LSB +: 4];
  // Sinks stay off in mode 11 and mode 00, whatever the force pin does.
  assign sinks_on = (mode == fst_pkg::MD_TORCH) ||
                    (mode == fst_pkg::MD_FLASH);
  // Triggers only count in flash mode; torch mode never looks at them.
  assign trig_level = strobe_s || sw_bit;
  assign trig_rise = (strobe_s && !strobe_d) || (sw_bit && !sw_d);
  assign timer_run = (state == fst_pkg::ST_LEVEL) ||
                     (state == fst_pkg::ST_SHOT);
  assign flash_active = timer_run;
  // The timer counts aclk, the internal oscillator, so its length tracks it.
  assign timer_timeout_event = timer_run && (tmr_cnt == 32'h1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_d <= 1'b0;
      sw_d <= 1'b0;
    end else begin
      strobe_d <= strobe_s;
      sw_d <= sw_bit;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || mode != fst_pkg::MD_FLASH) begin
      state <= fst_pkg::ST_IDLE;
    end else begin
      case (state)
        fst_pkg::ST_IDLE: begin
          if (trig_rise) begin
            state <= ttype ? fst_pkg::ST_SHOT : fst_pkg::ST_LEVEL;
          end
        end
        fst_pkg::ST_LEVEL: begin
          if (!trig_level) begin
            state <= fst_pkg::ST_IDLE;
          end else if (timer_timeout_event) begin
            state <= fst_pkg::ST_HOLD;
          end
        end
        fst_pkg::ST_SHOT: begin
          if (timer_timeout_event) begin
            state <= fst_pkg::ST_IDLE;
          end
        end
        fst_pkg::ST_HOLD: begin
          if (!trig_level) begin
            state <= fst_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= fst_pkg::ST_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || shutdown) begin
      tmr_cnt <= 32'h0;
    end else if (state == fst_pkg::ST_IDLE && trig_rise &&
                 mode == fst_pkg::MD_FLASH) begin
      tmr_cnt <= 32'(({29'h0, cfg.dur} + 32'h1) * FLASH_DURATION_SELECT_UNIT_CYC);
    end else if (timer_run) begin
      tmr_cnt <= tmr_cnt - 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Torch current runs the watchdog; a mode write or any break in torch current, such as a flash, restarts it.
  assign torch_on = sinks_on && !flash_active;
  assign wd_expire = torch_on && !mode_wr && (wd_cnt == 32'(WD_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || shutdown || mode_wr || !torch_on) begin
      wd_cnt <= 32'h0;
    end else if (wd_expire) begin
      wd_cnt <= 32'h0;
    end else begin
      wd_cnt <= wd_cnt + 32'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_wr) begin
      wd_fired <= 1'b0;
    end else if (wd_expire) begin
      wd_fired <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign target = !sinks_on ? 4'h0 :
                  flash_active ? lvl_q[`FST_FLASH_LSB +: 4] :
                  lvl_q[`FST_TORCH_LSB +: 4];
  assign period = cfg.res ? 16'(HC_CYC) :
                  (target > step) ? 16'(RISE_CYC) : 16'(FALL_CYC);
  // One code step per period; slow rise keeps battery surge low.
  always_ff @(posedge aclk) begin
    if (!aresetn || shutdown) begin
      step <= 4'h0;
      ramp_cnt <= 16'h0;
    end else if (step == target) begin
      ramp_cnt <= 16'h0;
    end else if (ramp_cnt >= period - 16'h1) begin
      step <= (target > step) ? step + 4'h1 : step - 4'h1;
      ramp_cnt <= 16'h0;
    end else begin
      ramp_cnt <= ramp_cnt + 16'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led <= '0;
    end else begin
      led.sink_en <= sinks_on ? cfg.sink : 3'h0;
      led.step <= step;
      led.current_qma <= 12'(step * (cfg.res ? `FST_QMA_HC :
                                     `FST_QMA_DD));
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn || !vm_active) begin
      down_mode <= 1'b0;
    end else if (pin_sync[1]) begin
      down_mode <= 1'b1;
    end else if (pin_sync[2]) begin
      down_mode <= 1'b0;
    end
  end
  assign psm_active = cfg.psm || down_mode;
  assign reverse_en = vm_active && !down_mode && pin_sync[3]
                      && pin_sync[4];
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] gap;
  always_ff @(posedge aclk) begin
    if (!aresetn || led.step != step) begin
      gap <= 16'h0;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h1;
    end
  end
  sequence s_shot_run;
    state == fst_pkg::ST_SHOT && !timer_timeout_event;
  endsequence
  sequence s_idle_edge;
    state == fst_pkg::ST_IDLE && trig_rise && mode == fst_pkg::MD_FLASH
    && !mode_wr;
  endsequence
  property p_down_enter;
    @(posedge aclk) disable iff (!aresetn)
      vm_active && pin_sync[1] && !mode_wr |=> down_mode || !vm_active;
  endproperty
  a_down_enter: assert property (p_down_enter)
    else $error("down mode not entered");
  property p_reverse;
    @(posedge aclk) disable iff (!aresetn) reverse_en |-> pin_sync[3];
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("reverse transfer with output not above input");
  property p_rise_gap;
    @(posedge aclk) disable iff (!aresetn)
      (led.step != step) && (step > led.step) && !cfg.res
      && $stable(cfg.res) && gap != 16'h0 |-> gap >= 16'(RISE_CYC - 1);
  endproperty
  a_rise_gap: assert property (p_rise_gap)
    else $error("direct drive rise step too fast");
  property p_scale;
    @(posedge aclk) disable iff (!aresetn)
      cfg.res && $stable(cfg.res) |->
        led.current_qma == 12'(led.step * `FST_QMA_HC);
  endproperty
  a_scale: assert property (p_scale)
    else $error("reservoir current not scaled");
  property p_psm;
    @(posedge aclk) disable iff (!aresetn) down_mode |-> psm_active;
  endproperty
  a_psm: assert property (p_psm)
    else $error("save mode off during down mode");
  property p_torch_ignore;
    @(posedge aclk) disable iff (!aresetn)
      mode == fst_pkg::MD_TORCH ##1 mode == fst_pkg::MD_TORCH
        |-> !flash_active;
  endproperty
  a_torch_ignore: assert property (p_torch_ignore)
    else $error("flash in torch mode");
  property p_wd;
    @(posedge aclk) disable iff (!aresetn)
      wd_expire |=> mode == fst_pkg::MD_OFF && wd_fired;
  endproperty
  a_wd: assert property (p_wd)
    else $error("watchdog did not shut down");
  property p_volt_off;
    @(posedge aclk) disable iff (!aresetn)
      mode == fst_pkg::MD_VOLT |=> !timer_run ##0 led.sink_en == 3'h0;
  endproperty
  a_volt_off: assert property (p_volt_off)
    else $error("sinks or timer on in voltage mode");
  property p_start;
    @(posedge aclk) disable iff (!aresetn)
      s_idle_edge |=> timer_run && (ttype ? state == fst_pkg::ST_SHOT :
                                     state == fst_pkg::ST_LEVEL);
  endproperty
  a_start: assert property (p_start)
    else $error("timer not started by edge");
  property p_level_stop;
    @(posedge aclk) disable iff (!aresetn)
      state == fst_pkg::ST_LEVEL && (!trig_level || timer_timeout_event)
        |=> !timer_run;
  endproperty
  a_level_stop: assert property (p_level_stop)
    else $error("level timer not stopped");
  property p_sw_clear;
    @(posedge aclk) disable iff (!aresetn)
      timer_timeout_event && !mode_wr |=> !sw_bit;
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("strobe bit kept after timeout");
  property p_shot_hold;
    @(posedge aclk) disable iff (!aresetn)
      s_shot_run ##0 mode == fst_pkg::MD_FLASH && !mode_wr |=> flash_active;
  endproperty
  a_shot_hold: assert property (p_shot_hold)
    else $error("one-shot ended before timeout");
  property p_force;
    @(posedge aclk) disable iff (!aresetn)
      force_s |-> vm_active && output_voltage_select == `FST_VOUT_FORCE;
  endproperty
  a_force: assert property (p_force)
    else $error("force pin not honoured");
  property p_off;
    @(posedge aclk) disable iff (!aresetn)
      shutdown |=> step == 4'h0 && tmr_cnt == 32'h0 && wd_cnt == 32'h0;
  endproperty
  a_off: assert property (p_off)
    else $error("shutdown left state behind");
endmodule // fst_timer

// [tb/fst_cam.sv]
// Camera module model that drives the strobe pin of the flash timer.
// Assumes the bench raises go once, just after a rising edge of aclk.
module fst_cam (
  input wire logic aclk,
  input wire logic go,
  output logic strobe_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  // The pin is push-pull, so it rests low between strobes.
  // A second strobe lands mid-flash, because a retrigger must not extend it.
  initial begin
    strobe_pin = 1'b0;
    @(posedge go);
    repeat (2) begin
      strobe_pin <= 1'b1;
      repeat (3) @(posedge aclk);
      strobe_pin <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  end
endmodule // fst_cam

// [tb/fst_timer_tb.sv]
// Self-checking bench for the flash strobe mode timer.
// Assumes the design package, header and the camera model are compiled.
module fst_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, strobe_pin, voltage_mode_force = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic vin_ge_vout = 1'b0, vin_below_vout_200mv = 1'b0;
  logic vout_above_vin = 1'b0, vout_above_target = 1'b0;
  fst_pkg::fst_led_s led;
  logic shutdown, vm_active, down_mode, psm_active, reverse_en;
  logic flash_active, timer_timeout_event;
  logic [3:0] output_voltage_select;
  int err_count = 0;
  int n_tests = 0;
  int n;
  int to_n;
  logic [1:0] b_resp;
  fst_timer #(.WD_CYC(200), .FLASH_DURATION_SELECT_UNIT_CYC(20), .RISE_CYC(4),
    .FALL_CYC(2), .HC_CYC(2)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .strobe_pin(strobe_pin),
    .voltage_mode_force(voltage_mode_force), .vin_ge_vout(vin_ge_vout),
    .vin_below_vout_200mv(vin_below_vout_200mv),
    .vout_above_vin(vout_above_vin), .vout_above_target(vout_above_target),
    .led(led), .shutdown(shutdown), .vm_active(vm_active),
    .output_voltage_select(output_voltage_select), .down_mode(down_mode),
    .psm_active(psm_active), .reverse_en(reverse_en),
    .flash_active(flash_active), .timer_timeout_event(timer_timeout_event)
  );
  fst_cam cam (.aclk(aclk), .go(go), .strobe_pin(strobe_pin));
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address and data are offered together; bready waits for the answer.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    while (!(s_axi_awready && s_axi_wready)) @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    b_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask
  // Waits for a flash and counts its cycles.
  // Starts off the edge, so a flash launched by that edge is not missed.
  task automatic flash_len;
    #1;
    repeat (50) if (flash_active !== 1'b1) cyc(1);
    n = 0;
    to_n = 0;
    while (flash_active === 1'b1 && n < 500) begin
      if (timer_timeout_event === 1'b1) to_n++;
      cyc(1);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_torch;
    cyc(1);
    chk("off", 32'h1, shutdown);
    rd(4'h2);
    chk("resp", 32'h0, rd_resp);
    chk("data", 32'h0, rd_data);
    wr(4'h8, 32'h0000_0804);
    chk("bresp", 32'h0, b_resp);
    wr(4'h0, 32'h5);
    cyc(30);
    chk("flash", 32'h0, flash_active);
    chk("cur", 32'h190, led.current_qma);
    cyc(200);
    chk("wdog", 32'h1, shutdown);
    chk("step", 32'h0, led.step);
    wr(4'h4, 32'h377);
    wr(4'h0, 32'h1);
    cyc(30);
    chk("hc", 32'h384, led.current_qma);
    $display("torch test done");
  endtask
  task automatic t_level;
    wr(4'h4, 32'h70);
    wr(4'h0, 32'h6);
    flash_len;
    chk("len", 32'd20, n);
    chk("to", 32'h1, to_n);
    rd(4'h0);
    chk("sw", 32'h2, rd_data);
    wr(4'h4, 32'h77);
    wr(4'h0, 32'h6);
    cyc(10);
    chk("on", 32'h1, flash_active);
    wr(4'h0, 32'h2);
    cyc(3);
    chk("stop", 32'h0, flash_active);
    $display("level test done");
  endtask
  task automatic t_edge;
    wr(4'h4, 32'h70);
    wr(4'h0, 32'ha);
    @(posedge aclk);
    go <= 1'b1;
    flash_len;
    chk("shot", 32'd20, n);
    chk("to1", 32'h1, to_n);
    cyc(30);
    chk("idle", 32'h0, flash_active);
    chk("torch", 32'h190, led.current_qma);
    $display("edge test done");
  endtask
  task automatic t_volt;
    wr(4'h0, 32'h3);
    cyc(3);
    chk("sink", 32'h0, led.sink_en);
    chk("vm", 32'h1, vm_active);
    @(posedge aclk);
    vin_ge_vout <= 1'b1;
    cyc(5);
    chk("down", 32'h1, down_mode);
    chk("psm", 32'h1, psm_active);
    @(posedge aclk);
    vin_ge_vout <= 1'b0;
    vin_below_vout_200mv <= 1'b1;
    cyc(5);
    chk("up", 32'h0, down_mode);
    @(posedge aclk);
    vout_above_vin <= 1'b1;
    vout_above_target <= 1'b1;
    cyc(4);
    chk("rev", 32'h1, reverse_en);
    @(posedge aclk);
    vout_above_vin <= 1'b0;
    cyc(4);
    chk("norev", 32'h0, reverse_en);
    wr(4'h0, 32'h0);
    @(posedge aclk);
    voltage_mode_force <= 1'b1;
    cyc(4);
    chk("ov", 32'h9, output_voltage_select);
    chk("fvm", 32'h1, vm_active);
    $display("voltage test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_torch;
    t_level;
    t_edge;
    t_volt;
    finish_test;
  end
  // The tests need under a thousand cycles, so this only cuts a hang.
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    finish_test;
  end
endmodule // fst_timer_tb
